// ---- src/lpm_regs.svh ----
// register offsets, field positions, reset values and step counts
`ifndef LPM_REGS_SVH
`define LPM_REGS_SVH
`define LPM_ADDR_W 6
`define LPM_CMD_OFS 6'h20
`define LPM_OPND_OFS 6'h24
`define LPM_OPFLG_OFS 6'h28
`define LPM_STAT_OFS 6'h2C
`define LPM_RESP_OKAY 2'h0
`define LPM_RESP_SLVERR 2'h2
`define LPM_OP_LOGP1 7'h06
`define LPM_OP_MOD 7'h21
`define LPM_COPROC_ID 3'h1
`define LPM_ID_LSB 25
`define LPM_RM_BIT 14
`define LPM_SPEC_LSB 10
`define LPM_DST_LSB 7
`define LPM_FMT_RSVD 3'h7
`define LPM_EXC_UNORDERED_BRANCH_FLAG 7
`define LPM_EXC_SIGNALING_NAN_FLAG 6
`define LPM_EXC_OPERAND_ERROR_FLAG 5
`define LPM_EXC_OVERFLOW_FLAG 4
`define LPM_EXC_UNDERFLOW_FLAG 3
`define LPM_EXC_DZ 2
`define LPM_EXC_INEXACT_RESULT_FLAG 1
`define LPM_EXC_DECIMAL_INPUT_INEXACT_FLAG 0
`define LPM_STAT_BUSY_BIT 16
`define LPM_STAT_ERR_BIT 17
`define LPM_MAG_INF 31'h7FFFFFFF
`define LPM_MAG_NAN 31'h7FFFFFFE
`define LPM_MAG_ONE 31'h00010000
`define LPM_VAL_NAN 32'h7FFFFFFE
`define LPM_INT_MAX 32'h00007FFF
`define LPM_LN2_Q16 32'h0000B172
`define LPM_NORM_K0 8'h0E
`define LPM_SQR_LAST 5'h0F
`define LPM_DIV_MSB 5'h1E
`define LPM_FPR_RST 32'h00000000
`endif

// ---- src/lpm_pkg.sv ----
// types shared by the log-plus-one and modulo unit
package lpm_pkg;
    typedef enum logic [1:0] {LPM_CS_IDLE = 2'b01, LPM_CS_RUN = 2'b10} lpm_cst_t;
    typedef enum logic [3:0] {
        LPM_ES_IDLE = 4'b0001, LPM_ES_NORM = 4'b0010,
        LPM_ES_SQR = 4'b0100, LPM_ES_DIV = 4'b1000
    } lpm_est_t;
    typedef enum logic {LPM_KIND_LOG = 1'b0, LPM_KIND_MOD = 1'b1} lpm_kind_t;
    typedef enum logic [2:0] {
        LPM_FMT_LONG = 3'h0, LPM_FMT_SINGLE = 3'h1, LPM_FMT_EXT = 3'h2,
        LPM_FMT_PACKED = 3'h3, LPM_FMT_WORD = 3'h4, LPM_FMT_DOUBLE = 3'h5,
        LPM_FMT_BYTE = 3'h6
    } lpm_fmt_t;
    typedef struct packed {
        lpm_cst_t st;
        logic awHave;
        logic wHave;
        logic [5:0] awAddr;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic bValid;
        logic [1:0] bResp;
        logic rValid;
        logic [31:0] rData;
        logic [1:0] rResp;
        logic [7:0][31:0] fpr;
        logic [31:0] opnd;
        logic opFlg;
        logic [7:0] quot;
        logic [7:0] exc;
        logic cmdErr;
        lpm_kind_t kind;
        logic [2:0] dst;
        logic sign;
        logic qSign;
        logic [7:0] pExc;
    } lpm_core_q_t;
    typedef struct packed {
        lpm_est_t st;
        logic [31:0] m;
        logic [7:0] k;
        logic [15:0] frac;
        logic [4:0] cnt;
        logic [31:0] a;
        logic [30:0] b;
        logic [31:0] rem;
        logic [30:0] quo;
        logic done;
        logic [31:0] res;
    } lpm_eng_q_t;
endpackage

// ---- src/lpm_iter_engine.sv ----
// iterative engine: fixed-point ln(1+x) and truncating remainder
`timescale 1ns/1ps
`include "lpm_regs.svh"
module lpm_iter_engine
    import lpm_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic start,
    input wire lpm_kind_t kind,
    input wire logic [31:0] opA,
    input wire logic [30:0] opB,
    output logic done,
    output logic [31:0] result,
    output logic [6:0] quotLow
);
    lpm_eng_q_t q, d;
    logic [63:0] prod;
    logic [31:0] sq;
    logic [15:0] fracN;
    logic [31:0] log2w;
    logic [63:0] lnProd;
    logic [31:0] remN;
    logic ge;

    // next-state: normalise, square for log bits, or restoring division
    always_comb
    begin
        d = q;
        d.done = 1'b0;
        prod = {32'h0, q.m} * {32'h0, q.m};
        sq = prod[61:30];
        fracN = {q.frac[14:0], sq[31]};
        log2w = {{8{q.k[7]}}, q.k, fracN};
        lnProd = {{32{log2w[31]}}, log2w} * {32'h0, `LPM_LN2_Q16};
        remN = {q.rem[30:0], q.a[q.cnt]};
        ge = remN >= {1'b0, q.b};
        case (q.st)
            LPM_ES_IDLE:
            begin
                if (start && kind == LPM_KIND_LOG)
                begin
                    d.st = LPM_ES_NORM;
                    d.m = opA;
                    d.k = `LPM_NORM_K0;
                    d.frac = 16'h0000;
                end
                else if (start)
                begin
                    d.st = LPM_ES_DIV;
                    d.cnt = `LPM_DIV_MSB;
                    d.a = opA;
                    d.b = opB;
                    d.rem = 32'h0000_0000;
                    d.quo = 31'h0000_0000;
                end
            end
            LPM_ES_NORM:
            begin
                if (q.m[31])
                begin
                    d.m = {1'b0, q.m[31:1]};
                    d.k = q.k + 8'h01;
                end
                else if (!q.m[30])
                begin
                    d.m = {q.m[30:0], 1'b0};
                    d.k = q.k - 8'h01;
                end
                else
                begin
                    d.st = LPM_ES_SQR;
                    d.cnt = `LPM_SQR_LAST;
                end
            end
            LPM_ES_SQR:
            begin
                d.m = sq[31] ? {1'b0, sq[31:1]} : sq;
                d.frac = fracN;
                d.cnt = q.cnt - 5'h01;
                if (q.cnt == 5'h00)
                begin
                    d.st = LPM_ES_IDLE;
                    d.done = 1'b1;
                    d.res = lnProd[47:16];
                end
            end
            LPM_ES_DIV:
            begin
                d.rem = ge ? remN - {1'b0, q.b} : remN;
                d.quo = {q.quo[29:0], ge};
                d.cnt = q.cnt - 5'h01;
                if (q.cnt == 5'h00)
                begin
                    d.st = LPM_ES_IDLE;
                    d.done = 1'b1;
                    d.res = ge ? remN - {1'b0, q.b} : remN;
                end
            end
            default: d.st = LPM_ES_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            q <= '0;
            q.st <= LPM_ES_IDLE;
        end
        else
            q <= d;
    end

    assign done = q.done;
    assign result = q.res;
    assign quotLow = q.quo[6:0];

    a_div_latency: assert property (@(posedge sys_clk) disable iff (rst)
        q.st == LPM_ES_IDLE && start && kind == LPM_KIND_MOD |-> ##32 done)
        else $error("remainder did not finish in 32 cycles");
endmodule // lpm_iter_engine

// ---- src/lpm_core.sv ----
// log-plus-one and modulo unit with its AXI4-Lite register slave
`timescale 1ns/1ps
`include "lpm_regs.svh"
module lpm_core
    import lpm_pkg::*;
#(
    parameter logic [2:0] COPROC_ID = `LPM_COPROC_ID
)(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [5:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [5:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    lpm_core_q_t q, d;
    logic [31:0] cmdWord, srcVal, dstVal, res, engA, engRes, lnAbs;
    logic [30:0] srcMag, dstMag;
    logic [6:0] engQuot;
    logic [7:0] newExc;
    logic [2:0] spec, dstIdx;
    logic rmBit, isLog, cmdLegal, doWrite, doCmd, execNow, engStart, engDone;
    logic srcNan, srcInf, dstNan, dstInf, fmtPacked, qSign;

    // byte-lane merge for partial writes
    function automatic logic [31:0] lpm_merge(input logic [31:0] old,
        input logic [31:0] nw, input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
            if (strb[i])
                r[i*8 +: 8] = nw[i*8 +: 8];
        return r;
    endfunction

    // integer formats become sign plus Q15.16 magnitude
    function automatic logic [31:0] lpm_conv(input logic [2:0] fmt, input logic [31:0] raw);
        logic [31:0] v;
        logic [31:0] a;
        v = raw;
        if (fmt == LPM_FMT_WORD)
            v = {{16{raw[15]}}, raw[15:0]};
        else if (fmt == LPM_FMT_BYTE)
            v = {{24{raw[7]}}, raw[7:0]};
        a = v[31] ? 32'h0000_0000 - v : v;
        if (fmt != LPM_FMT_LONG && fmt != LPM_FMT_WORD && fmt != LPM_FMT_BYTE)
            return raw;
        if (a > `LPM_INT_MAX)
            return {v[31], `LPM_MAG_INF};
        return {v[31], a[14:0], 16'h0000};
    endfunction

    lpm_iter_engine u_engine (
        .sys_clk(sys_clk),
        .rst(rst),
        .start(engStart),
        .kind(isLog ? LPM_KIND_LOG : LPM_KIND_MOD),
        .opA(engA),
        .opB(srcMag),
        .done(engDone),
        .result(engRes),
        .quotLow(engQuot)
    );

    // command decode, bus slave, special operands and result write-back
    always_comb
    begin
        d = q;
        cmdWord = lpm_merge(32'h0000_0000, q.wData, q.wStrb);
        spec = cmdWord[`LPM_SPEC_LSB +: 3];
        dstIdx = cmdWord[`LPM_DST_LSB +: 3];
        rmBit = cmdWord[`LPM_RM_BIT];
        isLog = cmdWord[6:0] == `LPM_OP_LOGP1;
        cmdLegal = cmdWord[`LPM_ID_LSB +: 3] == COPROC_ID && !cmdWord[15]
            && !cmdWord[13] && (isLog || cmdWord[6:0] == `LPM_OP_MOD)
            && !(rmBit && spec == `LPM_FMT_RSVD);
        srcVal = rmBit ? lpm_conv(spec, q.opnd) : q.fpr[spec];
        dstVal = q.fpr[dstIdx];
        srcMag = srcVal[30:0];
        dstMag = dstVal[30:0];
        srcNan = srcMag == `LPM_MAG_NAN;
        srcInf = srcMag == `LPM_MAG_INF;
        dstNan = dstMag == `LPM_MAG_NAN;
        dstInf = dstMag == `LPM_MAG_INF;
        qSign = srcVal[31] ^ dstVal[31];
        fmtPacked = rmBit && spec == LPM_FMT_PACKED;
        doWrite = q.awHave && q.wHave && !q.bValid;
        doCmd = doWrite && q.awAddr == `LPM_CMD_OFS;
        execNow = doCmd && cmdLegal && q.st == LPM_CS_IDLE;
        engStart = 1'b0;
        engA = isLog ? (srcVal[31] ? {1'b0, `LPM_MAG_ONE - srcMag}
            : {1'b0, `LPM_MAG_ONE} + {1'b0, srcMag}) : {1'b0, dstMag};
        res = `LPM_VAL_NAN;
        newExc = 8'h00;
        newExc[`LPM_EXC_DECIMAL_INPUT_INEXACT_FLAG] = fmtPacked && q.opFlg;
        lnAbs = engRes[31] ? 32'h0000_0000 - engRes : engRes;
        // write channel capture
        if (s_axi_awvalid && !q.awHave)
        begin
            d.awHave = 1'b1;
            d.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !q.wHave)
        begin
            d.wHave = 1'b1;
            d.wData = s_axi_wdata;
            d.wStrb = s_axi_wstrb;
        end
        if (q.bValid && s_axi_bready)
            d.bValid = 1'b0;
        // register write and command issue
        if (doWrite)
        begin
            d.awHave = 1'b0;
            d.wHave = 1'b0;
            d.bValid = 1'b1;
            d.bResp = `LPM_RESP_OKAY;
            if (!q.awAddr[5])
                d.fpr[q.awAddr[4:2]] = lpm_merge(q.fpr[q.awAddr[4:2]], q.wData, q.wStrb);
            else if (q.awAddr == `LPM_OPND_OFS)
                d.opnd = lpm_merge(q.opnd, q.wData, q.wStrb);
            else if (q.awAddr == `LPM_OPFLG_OFS)
                d.opFlg = q.wStrb[0] ? q.wData[0] : q.opFlg;
            else if (doCmd && q.st != LPM_CS_IDLE)
                d.bResp = `LPM_RESP_SLVERR;
            else if (doCmd)
                d.cmdErr = !cmdLegal;
            else
                d.bResp = `LPM_RESP_SLVERR;
        end
        // log-plus-one special operands; quotient byte is never written here
        if (execNow && isLog)
        begin
            if (srcNan)
                res = `LPM_VAL_NAN;
            else if (srcMag == 31'h0000_0000)
                res = srcVal;
            else if (srcInf && !srcVal[31])
                res = srcVal;
            else if (srcInf)
                newExc[`LPM_EXC_OPERAND_ERROR_FLAG] = 1'b1;
            else if (srcVal[31] && srcMag == `LPM_MAG_ONE)
                newExc[`LPM_EXC_DZ] = 1'b1;
            else if (srcVal[31] && srcMag > `LPM_MAG_ONE)
                newExc[`LPM_EXC_OPERAND_ERROR_FLAG] = 1'b1;
            else
                engStart = 1'b1;
        end
        // modulo special operands
        if (execNow && !isLog)
        begin
            d.quot = {qSign, 7'h00};
            if (srcNan || dstNan)
                res = `LPM_VAL_NAN;
            else if (srcMag == 31'h0000_0000 || dstInf)
                newExc[`LPM_EXC_OPERAND_ERROR_FLAG] = 1'b1;
            else if (dstMag == 31'h0000_0000)
                res = {dstVal[31], 31'h0000_0000};
            else if (srcInf)
                res = dstVal;
            else
                engStart = 1'b1;
        end
        if (execNow && engStart)
        begin
            d.st = LPM_CS_RUN;
            d.kind = isLog ? LPM_KIND_LOG : LPM_KIND_MOD;
            d.dst = dstIdx;
            d.sign = isLog ? srcVal[31] : dstVal[31];
            d.qSign = qSign;
            d.pExc = newExc;
        end
        else if (execNow)
        begin
            d.fpr[dstIdx] = res;
            d.exc = newExc;
        end
        // engine result write-back
        if (engDone && q.st == LPM_CS_RUN)
        begin
            d.st = LPM_CS_IDLE;
            d.exc = q.pExc;
            if (q.kind == LPM_KIND_LOG)
            begin
                d.fpr[q.dst] = {q.sign, lnAbs[30:0]};
                d.exc[`LPM_EXC_INEXACT_RESULT_FLAG] = lnAbs != 32'h0000_0000;
            end
            else
            begin
                d.fpr[q.dst] = {q.sign, engRes[30:0]};
                d.quot = {q.qSign, engQuot};
            end
        end
        // read channel
        if (q.rValid && s_axi_rready)
            d.rValid = 1'b0;
        if (s_axi_arvalid && !q.rValid)
        begin
            d.rValid = 1'b1;
            d.rResp = `LPM_RESP_OKAY;
            d.rData = 32'h0000_0000;
            if (!s_axi_araddr[5])
                d.rData = q.fpr[s_axi_araddr[4:2]];
            else if (s_axi_araddr == `LPM_OPND_OFS)
                d.rData = q.opnd;
            else if (s_axi_araddr == `LPM_OPFLG_OFS)
                d.rData = {31'h0000_0000, q.opFlg};
            else if (s_axi_araddr == `LPM_STAT_OFS)
                d.rData = {14'h0000, q.cmdErr, q.st == LPM_CS_RUN, q.quot, q.exc};
            else if (s_axi_araddr != `LPM_CMD_OFS)
                d.rResp = `LPM_RESP_SLVERR;
        end
    end

    // state register
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            q <= '0;
            q.st <= LPM_CS_IDLE;
        end
        else
            q <= d;
    end

    // bus outputs
    assign s_axi_awready = !q.awHave;
    assign s_axi_wready = !q.wHave;
    assign s_axi_bvalid = q.bValid;
    assign s_axi_bresp = q.bResp;
    assign s_axi_arready = !q.rValid;
    assign s_axi_rvalid = q.rValid;
    assign s_axi_rdata = q.rData;
    assign s_axi_rresp = q.rResp;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    sequence s_log_cmd;
        execNow && isLog;
    endsequence
    sequence s_mod_run;
        execNow && !isLog && engStart ##1 q.st == LPM_CS_RUN;
    endsequence

    a_log_minus_one: assert property (s_log_cmd and srcVal == {1'b1, `LPM_MAG_ONE}
        |=> q.exc[`LPM_EXC_DZ] && q.fpr[$past(dstIdx)] == `LPM_VAL_NAN)
        else $error("log of -1 wrong");
    a_log_below_one: assert property (s_log_cmd and srcVal[31] && !srcNan
        && srcMag > `LPM_MAG_ONE |=> q.exc[`LPM_EXC_OPERAND_ERROR_FLAG] && !q.exc[`LPM_EXC_DZ])
        else $error("log below -1 wrong");
    a_log_zero: assert property (s_log_cmd and srcMag == 31'h0000_0000
        |=> q.fpr[$past(dstIdx)] == $past(srcVal))
        else $error("log of zero lost its sign");
    a_log_flags: assert property (engDone && q.st == LPM_CS_RUN && q.kind == LPM_KIND_LOG
        |=> !q.exc[`LPM_EXC_DZ] && !q.exc[`LPM_EXC_UNORDERED_BRANCH_FLAG] && !q.exc[`LPM_EXC_OVERFLOW_FLAG])
        else $error("log flags not cleared");
    a_bad_id: assert property (doCmd && q.st == LPM_CS_IDLE
        && cmdWord[`LPM_ID_LSB +: 3] != COPROC_ID |=> q.st == LPM_CS_IDLE && q.cmdErr)
        else $error("foreign command executed");
    a_mod_quot: assert property (s_mod_run |-> ##[30:40] engDone ##1
        q.st == LPM_CS_IDLE && q.quot[7] == q.qSign)
        else $error("modulo quotient byte wrong");
    a_mod_operand_error_flag: assert property (execNow && !isLog && !srcNan && !dstNan
        && (srcMag == 31'h0000_0000 || dstInf) |=> q.exc[`LPM_EXC_OPERAND_ERROR_FLAG])
        else $error("modulo operand error missing");
    a_mod_inf_src: assert property (execNow && !isLog && srcInf && !dstNan
        && !dstInf && dstMag != 31'h0000_0000 |=> q.fpr[$past(dstIdx)] == $past(dstVal))
        else $error("modulo infinite source changed value");
    a_mod_zero_dst: assert property (execNow && !isLog && dstMag == 31'h0000_0000
        && !srcNan && srcMag != 31'h0000_0000 |=> q.fpr[$past(dstIdx)][30:0] == 31'h0000_0000)
        else $error("modulo zero destination wrong");
    a_mod_flags: assert property (engDone && q.st == LPM_CS_RUN && q.kind == LPM_KIND_MOD
        |=> !q.exc[`LPM_EXC_DZ] && !q.exc[`LPM_EXC_OVERFLOW_FLAG] && !q.exc[`LPM_EXC_OPERAND_ERROR_FLAG]
        && !q.exc[`LPM_EXC_UNORDERED_BRANCH_FLAG])
        else $error("modulo flags not cleared");
    a_log_quot: assert property (s_log_cmd |=> $stable(q.quot) [*3])
        else $error("log changed quotient byte");
    a_decimal_input_inexact_flag_fmt: assert property (execNow && !engStart && !fmtPacked
        |=> !q.exc[`LPM_EXC_DECIMAL_INPUT_INEXACT_FLAG])
        else $error("decimal inexact set for binary format");
endmodule // lpm_core

// ---- bench/lpm_host_model.sv ----
// host model: AXI4-Lite master that issues coprocessor commands
`timescale 1ns/1ps
module lpm_host_model (
    input wire logic sys_clk,
    output logic [5:0] awAddr,
    output logic awValid,
    input wire logic awReady,
    output logic [31:0] wData,
    output logic wValid,
    input wire logic wReady,
    input wire logic [1:0] bResp,
    input wire logic bValid,
    output logic bReady,
    output logic [5:0] arAddr,
    output logic arValid,
    input wire logic arReady,
    input wire logic [31:0] rData,
    input wire logic [1:0] rResp,
    input wire logic rValid,
    output logic rReady
);
    // bus idle at time zero
    initial
    begin
        {awAddr, awValid, wData, wValid, bReady, arAddr, arValid, rReady} = '0;
    end
    // command word: address field zero in register mode, immediate in memory mode
    function automatic logic [31:0] mk(input logic rm, input logic [2:0] sp,
        input logic [2:0] ds, input logic [6:0] op, input logic [2:0] id);
        logic [5:0] ea;
        ea = rm ? 6'h3C : 6'h00;
        return {4'hF, id, 3'h0, ea, 1'b0, rm, 1'b0, sp, ds, op};
    endfunction
    // one transfer; each channel is released at the edge that takes it
    task automatic xf(input bit wr, input logic [5:0] a, inout logic [31:0] d,
        output logic [1:0] r, output bit to);
        // let an edge pass so the previous release and this request never share a time step
        @(posedge sys_clk);
        to = 1'b1;
        awAddr <= a;
        arAddr <= a;
        wData <= d;
        {awValid, wValid, bReady} <= {3{wr}};
        {arValid, rReady} <= {2{!wr}};
        for (int n = 0; n < 300 && to; n++)
        begin
            @(posedge sys_clk);
            if ((bValid && bReady) || (rValid && rReady))
            begin
                r = wr ? bResp : rResp;
                d = rData;
                {bReady, rReady} <= 2'b00;
                to = 1'b0;
            end
            if (awValid && awReady)
                {awValid, awAddr} <= {1'b0, ~a}; // released address no longer stale
            if (wValid && wReady)
                {wValid, wData} <= {1'b0, ~d};
            if (arValid && arReady)
                {arValid, arAddr} <= {1'b0, ~a};
        end
    endtask
endmodule // lpm_host_model

// ---- bench/tb_log_plus_one_and_modulo_unit.sv ----
// self-checking bench for the log-plus-one and modulo unit
`timescale 1ns/1ps
`include "lpm_regs.svh"
module tb_log_plus_one_and_modulo_unit
    import lpm_pkg::*;
;
    localparam logic [31:0] NEG1 = 32'h80010000;
    localparam logic [31:0] ONE = {1'b0, `LPM_MAG_ONE};
    localparam logic [31:0] NAN = `LPM_VAL_NAN;
    localparam logic [31:0] SEVEN = 32'h00070000;
    localparam logic [6:0] LG = `LPM_OP_LOGP1;
    localparam logic [6:0] MD = `LPM_OP_MOD;
    localparam logic [2:0] ID = `LPM_COPROC_ID;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic awValid, awReady, wValid, wReady, bValid, bReady, arValid, arReady, rValid, rReady;
    logic [5:0] awAddr, arAddr;
    logic [31:0] wData, rData, d, st;
    logic [1:0] bResp, rResp, rs;
    bit to;
    int fails = 0;
    int nCompared = 0;
    // operand and result tables
    logic [31:0] lsv [6] = '{32'h80000000, 32'h0, 32'h7FFFFFFF, 32'hFFFFFFFF, 32'h80008000, ONE};
    logic [31:0] lsr [6] = '{32'h80000000, 32'h0, 32'h7FFFFFFF, NAN, 32'h8000B172, 32'h0000B172};
    logic [31:0] fmv [7] = '{32'hFFFFFFFF, NEG1, NEG1, NEG1, 32'h0000FFFF, NEG1, 32'h000000FF};
    logic [31:0] mdd [4] = '{SEVEN, 32'h7FFFFFFF, SEVEN, 32'h80000000};
    logic [31:0] mds [4] = '{32'h0, 32'h00020000, 32'h7FFFFFFF, 32'h00030000};
    logic [31:0] mdr [4] = '{NAN, NAN, SEVEN, 32'h80000000};
    // 50 ns clock
    always #25 sys_clk = ~sys_clk;
    lpm_core #(.COPROC_ID(ID)) dut (.sys_clk(sys_clk), .rst(rst),
        .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
        .s_axi_wdata(wData), .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
        .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
        .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
        .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady));
    lpm_host_model host (.sys_clk, .awAddr, .awValid, .awReady, .wData, .wValid, .wReady,
        .bResp, .bValid, .bReady, .arAddr, .arValid, .arReady, .rData, .rResp, .rValid, .rReady);
    // verdict and end of run
    task automatic close_out();
        $display("compared %0d mismatches %0d", nCompared, fails);
        if (fails == 0 && nCompared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        nCompared++;
        if (g !== e)
        begin
            fails++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one bus cycle with its expected response
    task automatic bus(input bit w, input logic [5:0] a, input logic [31:0] v, input logic [1:0] e);
        d = v;
        host.xf(w, a, d, rs, to);
        if (to)
        begin
            fails++;
            $display("Error bus expected response seen timeout");
            close_out();
        end
        chk("resp", {30'h0, e}, {30'h0, rs});
    endtask
    task automatic wf(input logic [2:0] r, input logic [31:0] v);
        bus(1, {1'b0, r, 2'b00}, v, 2'h0);
    endtask
    task automatic rr(input logic [2:0] r, input logic [31:0] e);
        bus(0, {1'b0, r, 2'b00}, 32'h0, 2'h0);
        chk("fpr", e, d);
    endtask
    // issue a command, then poll status until idle
    task automatic run(input logic [31:0] c, input logic [1:0] e);
        bus(1, `LPM_CMD_OFS, c, e);
        for (int n = 0; n < 100; n++)
        begin
            bus(0, `LPM_STAT_OFS, 32'h0, 2'h0);
            st = d;
            if (st[`LPM_STAT_BUSY_BIT] === 1'b0)
                return;
        end
        fails++;
        $display("Error busy expected 0 seen 1");
        close_out();
    endtask
    task automatic ex(input logic [7:0] e);
        chk("exc", {24'h0, e}, {24'h0, st[7:0] & 8'hB5});
    endtask
    // main sequence
    initial
    begin
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        bus(0, `LPM_STAT_OFS, 32'h0, 2'h0);
        chk("status", 32'h0, d);
        bus(0, 6'h30, 32'h0, `LPM_RESP_SLVERR);
        bus(1, `LPM_STAT_OFS, 32'h1, `LPM_RESP_SLVERR);
        wf(1, NEG1);
        run(host.mk(0, 1, 2, LG, ID), 2'h0);
        ex(8'h04);
        rr(2, NAN);
        bus(1, `LPM_OPND_OFS, 32'h80020000, 2'h0);
        run(host.mk(1, LPM_FMT_EXT, 3, LG, ID), 2'h0);
        ex(8'h20);
        rr(3, NAN);
        for (int i = 0; i < 6; i++)
        begin
            bus(1, `LPM_OPND_OFS, lsv[i], 2'h0);
            run(host.mk(1, LPM_FMT_EXT, 3, LG, ID), 2'h0);
            ex(i == 3 ? 8'h20 : 8'h00);
            rr(3, lsr[i]);
        end
        for (int f = 0; f < 7; f++)
        begin
            wf(4, ONE);
            bus(1, `LPM_OPND_OFS, fmv[f], 2'h0);
            run(host.mk(1, 3'(f), 4, LG, ID), 2'h0);
            ex(8'h04);
            rr(4, NAN);
        end
        // modulo, then log keeps the quotient byte
        wf(5, SEVEN);
        wf(6, 32'h80020000);
        run(host.mk(0, 6, 5, MD, ID), 2'h0);
        ex(8'h00);
        chk("quot", 32'h83, {24'h0, st[15:8]});
        rr(5, ONE);
        wf(1, 32'h0);
        run(host.mk(0, 1, 2, LG, ID), 2'h0);
        chk("quot", 32'h83, {24'h0, st[15:8]});
        wf(3, 32'h00050000);
        run(host.mk(0, 3, 3, MD, ID), 2'h0);
        rr(3, 32'h0);
        chk("quot", 32'h01, {24'h0, st[15:8]});
        for (int i = 0; i < 4; i++)
        begin
            wf(5, mdd[i]);
            wf(6, mds[i]);
            run(host.mk(0, 6, 5, MD, ID), 2'h0);
            ex(i < 2 ? 8'h20 : 8'h00);
            rr(5, mdr[i]);
        end
        bus(1, `LPM_OPFLG_OFS, 32'h1, 2'h0);
        bus(1, `LPM_OPND_OFS, 32'h00020000, 2'h0);
        for (int i = 0; i < 2; i++)
        begin
            wf(5, SEVEN);
            run(host.mk(1, i ? LPM_FMT_EXT : LPM_FMT_PACKED, 5, MD, ID), 2'h0);
            ex(i ? 8'h00 : 8'h01);
            rr(5, ONE);
        end
        // a busy unit refuses a second command
        wf(1, ONE);
        wf(7, 32'h0);
        bus(1, `LPM_CMD_OFS, host.mk(0, 1, 2, LG, ID), 2'h0);
        run(host.mk(0, 1, 7, LG, ID), `LPM_RESP_SLVERR);
        rr(7, 32'h0);
        bus(0, 6'h08, 32'h0, 2'h0);
        chk("ln2", 32'hB1, {8'h0, d[31:8]});
        // foreign unit number and reserved format
        wf(5, SEVEN);
        run(host.mk(0, 6, 5, MD, 3'h2), 2'h0);
        chk("cmderr", 32'h1, {31'h0, st[`LPM_STAT_ERR_BIT]});
        rr(5, SEVEN);
        run(host.mk(1, 3'h7, 5, LG, ID), 2'h0);
        chk("cmderr", 32'h1, {31'h0, st[`LPM_STAT_ERR_BIT]});
        rr(5, SEVEN);
        // a command word with bit 13 set is refused
        run(host.mk(0, 6, 5, MD, ID) | 32'h00002000, 2'h0);
        chk("cmderr", 32'h1, {31'h0, st[`LPM_STAT_ERR_BIT]});
        rr(5, SEVEN);
        close_out();
    end
endmodule // tb_log_plus_one_and_modulo_unit
